// ---- dv/erb_checker.sv ----
`timescale 1ns/1ps
module erb_checker
(
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata
);
   default clocking erb_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready not a pulse");
   b_after_a: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   r_after_a: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
      else $error("read data without request");
   rst_clear_a: assert property (!$past(aresetn)
      |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready && !s_axi_arready)
      else $error("outputs not cleared by reset");
endmodule // erb_checker
bind erb_top erb_checker chk_u (.*);

// ---- dv/erb_host.sv ----
`timescale 1ns/1ps
module erb_host
(
   input  wire         aclk,
   output logic [7:0]  s_axi_awaddr = 8'h00,
   output logic        s_axi_awvalid = 1'b0,
   input  wire         s_axi_awready,
   output logic [31:0] s_axi_wdata = 32'h0000_0000,
   output logic [3:0]  s_axi_wstrb = 4'hf,
   output logic        s_axi_wvalid = 1'b0,
   input  wire         s_axi_wready,
   input  wire  [1:0]  s_axi_bresp,
   input  wire         s_axi_bvalid,
   output logic        s_axi_bready = 1'b0,
   output logic [7:0]  s_axi_araddr = 8'h00,
   output logic        s_axi_arvalid = 1'b0,
   input  wire         s_axi_arready,
   input  wire  [31:0] s_axi_rdata,
   input  wire  [1:0]  s_axi_rresp,
   input  wire         s_axi_rvalid,
   output logic        s_axi_rready = 1'b0
);
   // Each call starts one edge late so no strobe is assigned twice in a time step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      s_axi_awaddr <= ~a; // Released payload must not look valid
      s_axi_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_araddr <= ~a;
   endtask
endmodule // erb_host

// ---- dv/test_embedded_ram_block_modes.sv ----
`timescale 1ns/1ps
`include "erb_consts.vh"
module test_embedded_ram_block_modes;
   typedef struct packed {
      logic [11:0] ctrl;
      logic [3:0]  a;
      logic [3:0]  b;
      logic [31:0] d;
      logic [3:0]  cmd;
      logic        rb;
      logic [31:0] exp;
   } erb_row_t;
   localparam logic [31:0] dc = 32'hadbe_ef00;
   localparam erb_row_t rows [17] = '{
      '{12'h000, 4'h5, 4'h0, 32'h1234_5678, 4'h1, 1'b1, 32'h0000_0000},
      '{12'h000, 4'h5, 4'h0, 32'h0000_0000, 4'h2, 1'b0, 32'h1234_5678},
      '{12'h008, 4'h6, 4'h0, 32'ha5a5_0001, 4'h3, 1'b0, 32'ha5a5_0001},
      '{12'h000, 4'h7, 4'h0, 32'h0f0f_0f0f, 4'h3, 1'b0, dc},
      '{12'h080, 4'h9, 4'h0, 32'h1111_1111, 4'h1, 1'b0, dc},
      '{12'h001, 4'h5, 4'h5, 32'h0bad_cafe, 4'h9, 1'b1, 32'h1234_5678},
      '{12'h051, 4'h5, 4'h5, 32'h7777_0000, 4'h9, 1'b1, 32'h7777_0000},
      '{12'h021, 4'h5, 4'h5, 32'h2222_0000, 4'h9, 1'b1, dc},
      '{12'h001, 4'h8, 4'h6, 32'h3333_0000, 4'h9, 1'b1, 32'ha5a5_0001},
      '{12'h202, 4'h8, 4'h8, 32'h4444_0000, 4'h9, 1'b1, dc},
      '{12'h002, 4'h8, 4'ha, 32'h0000_00b0, 4'h6, 1'b0, 32'h4444_0000},
      '{12'h002, 4'ha, 4'h0, 32'h0000_0000, 4'h2, 1'b0, 32'h0000_00b0},
      '{12'h004, 4'h5, 4'h0, 32'h5555_0000, 4'h1, 1'b0, 32'h0000_00b0},
      '{12'h004, 4'h5, 4'h0, 32'h0000_0000, 4'h2, 1'b0, 32'h2222_0000},
      '{12'h100, 4'h5, 4'h0, 32'h0000_0000, 4'h0, 1'b0, 32'h0000_0000},
      '{12'h000, 4'h5, 4'h0, 32'h0000_0000, 4'h2, 1'b0, 32'h2222_0000},
      '{12'h003, 4'h0, 4'h0, 32'h6666_0000, 4'h1, 1'b0, 32'h0000_0000}};
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   wire  [7:0]  s_axi_awaddr, s_axi_araddr;
   wire  [31:0] s_axi_wdata, s_axi_rdata;
   wire  [3:0]  s_axi_wstrb;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          err_count = 0;
   int          check_count = 0;
   always #12.5 aclk = ~aclk;
   erb_top dut_u (.*);
   erb_host host_u (.*);
   task automatic cmp(input logic [33:0] got, input logic [33:0] want);
      check_count++;
      if (got !== want)
      begin
         err_count++;
         $display("ERROR %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      host_u.wr(a, d, r);
      cmp({r, 32'h0000_0000}, {er, 32'h0000_0000});
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      host_u.rd(a, d, r);
      cmp({r, d}, {er, e});
   endtask
   task automatic reset_check;
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rreg(`ERB_REG_CTRL, {22'h00_0000, `ERB_CTRL_RST}, 2'h0);
      rreg(`ERB_REG_RDATA, 32'h0000_0000, 2'h0);
      rreg(`ERB_REG_RDATAB, 32'h0000_0000, 2'h0);
      rreg(`ERB_REG_STAT, 32'h0000_0000, 2'h0);
      $display("reset test done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      reset_check();
      foreach (rows[i])
      begin
         wreg(`ERB_REG_CTRL, {20'h0_0000, rows[i].ctrl}, 2'h0);
         wreg(`ERB_REG_ADDR, {28'h000_0000, rows[i].a}, 2'h0);
         wreg(`ERB_REG_ADDRB, {28'h000_0000, rows[i].b}, 2'h0);
         wreg(`ERB_REG_WDATA, rows[i].d, 2'h0);
         wreg(`ERB_REG_CMD, {28'h000_0000, rows[i].cmd}, 2'h0);
         repeat (2) @(posedge aclk);
         rreg(rows[i].rb ? `ERB_REG_RDATAB : `ERB_REG_RDATA, rows[i].exp, 2'h0);
         $display("row %0d done", i);
      end
      wreg(8'h20, 32'h0000_0001, 2'h2);
      rreg(8'h24, 32'h0000_0000, 2'h0);
      rreg(`ERB_REG_CMD, 32'h0000_0000, 2'h0);
      $display("refusal test done");
      reset_check();
      finish_test();
   end
   // Rows take about 31 cycles each, so this leaves a wide margin
   initial
   begin
      repeat (5000) @(posedge aclk);
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      finish_test();
   end
endmodule // test_embedded_ram_block_modes

// ---- logic/erb_consts.vh ----
`ifndef ERB_CONSTS_VH
`define ERB_CONSTS_VH
// Register byte offsets
`define ERB_REG_CTRL      8'h00
`define ERB_REG_STAT      8'h04
`define ERB_REG_ADDR      8'h08
`define ERB_REG_WDATA     8'h0c
`define ERB_REG_RDATA     8'h10
`define ERB_REG_CMD       8'h14
`define ERB_REG_ADDRB     8'h18
`define ERB_REG_RDATAB    8'h1c
// Control fields
`define ERB_CTRL_MODE_LO  0
`define ERB_CTRL_MODE_HI  2
`define ERB_CTRL_SP_NEW   3
`define ERB_CTRL_MP_LO    4
`define ERB_CTRL_MP_HI    5
`define ERB_CTRL_OREG     6
`define ERB_CTRL_RDEN     7
`define ERB_CTRL_CLR      8
`define ERB_CTRL_DIFFCLK  9
`define ERB_CTRL_W        10
`define ERB_CTRL_RST      10'h000
// Memory modes
`define ERB_MODE_SP       3'h0
`define ERB_MODE_SDP      3'h1
`define ERB_MODE_TDP      3'h2
`define ERB_MODE_SHIFT    3'h3
`define ERB_MODE_ROM      3'h4
// Mixed-port modes
`define ERB_MP_OLD        2'h0
`define ERB_MP_NEW        2'h1
`define ERB_MP_DC         2'h2
// Command bits
`define ERB_CMD_WRA       0
`define ERB_CMD_RDA       1
`define ERB_CMD_WRB       2
`define ERB_CMD_RDB       3
// Geometry: 512 x 40 words
`define ERB_AW            9
`define ERB_DW            40
`define ERB_DEPTH         512
// Fill value for undefined read results
`define ERB_DC_WORD       40'hdead_beef_00
// Shift mode taps
`define ERB_TAP_LEN       9'h010
`endif

// ---- logic/erb_ram.v ----
`timescale 1ns/1ps
`include "erb_consts.vh"
module erb_ram
(
   input  wire                 aclk,
   input  wire                 we_a,
   input  wire [`ERB_AW-1:0]   addr_a,
   input  wire [`ERB_DW-1:0]   wdata_a,
   output reg  [`ERB_DW-1:0]   rdata_a,
   input  wire                 we_b,
   input  wire [`ERB_AW-1:0]   addr_b,
   input  wire [`ERB_DW-1:0]   wdata_b,
   output reg  [`ERB_DW-1:0]   rdata_b
);
   // 512 words of 40 bits: 20,480 bits with parity
   reg [`ERB_DW-1:0] mem [0:`ERB_DEPTH-1];
   integer i;
   // Cells start at zero unless preloaded
   initial
   begin
      for (i = 0; i < `ERB_DEPTH; i = i + 1)
         mem[i] = {`ERB_DW{1'b0}};
   end
   // Reads see old contents; new-data bypass is done in the top
   always @(posedge aclk)
   begin
      rdata_a <= mem[addr_a];
      rdata_b <= mem[addr_b];
      if (we_a)
         mem[addr_a] <= wdata_a;
      if (we_b)
         mem[addr_b] <= wdata_b;
   end
endmodule // erb_ram

// ---- logic/erb_top.v ----
// Notes on behaviour
// - Same-port new-data mode outputs the written word in the write cycle.
// - Same-port don't-care mode returns an undefined word on same-address write.
// - Mixed-port behaviour applies when the ports read and write one address; here only a port B read of a port A write.
// - Mixed-port new data shows on the registered output next edge.
// - Mixed-port old data returns the word stored before the write.
// - Mixed-port don't-care returns an undefined word on collision.
// - Defined mixed-port results need one clock for both ports.
// - Outputs are cleared at reset regardless of output registering.
// - Cells start at zero; outputs start cleared even when preloaded.
// - Large block capacity 20,480 bits; logic memory 640 bits.
// - Reads and writes happen on rising clock edges.
// - Clear affects only the output registers.
// - Built-in correction only in 32-bit simple dual-port; not provided here.
// - Write with read enable low keeps the last read output.
// - Write with read enable high follows the same-port mode; port B here returns the old stored word.
// - Simple dual-port allows a port A write and port B read together.
// - True dual-port accepts any pair of port operations.
// - Shift mode storage is width times tap length times taps.
// - ROM mode blocks writes and reads like single-port.
// - Large block runs to 730 MHz, logic memory to 700 MHz.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "erb_consts.vh"
module erb_top
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   reg  [`ERB_CTRL_W-1:0] ctrl_r;
   reg  [`ERB_AW-1:0]     addr_a_r;
   reg  [`ERB_AW-1:0]     addr_b_r;
   reg  [`ERB_DW-1:0]     wdata_r;
   reg  [`ERB_DW-1:0]     dout_a_r;
   reg  [`ERB_DW-1:0]     dout_b_r;
   reg  [7:0]             aw_addr_r;
   reg  [31:0]            w_data_r;
   reg  [3:0]             w_strb_r;
   reg                    aw_have_r;
   reg                    w_have_r;
   reg  [3:0]             cmd_r;
   reg                    pend_r;
   reg  [3:0]             pcmd_r;
   reg                    coll_r;
   reg                    rsel_a_r;
   reg                    rsel_b_r;
   reg  [`ERB_AW-1:0]     shift_ptr_r;
   reg  [7:0]             opcount_r;
   wire [2:0]             mode;
   wire [1:0]             mp_mode;
   wire                   sp_new;
   wire                   oreg;
   wire                   rden_cfg;
   wire                   diffclk;
   wire                   is_shift;
   wire                   is_rom;
   wire                   do_wa;
   wire                   do_ra;
   wire                   do_wb;
   wire                   do_rb;
   wire [`ERB_AW-1:0]     ram_addr_a;
   wire [`ERB_AW-1:0]     ram_addr_b;
   wire [`ERB_DW-1:0]     ram_q_a;
   wire [`ERB_DW-1:0]     ram_q_b;
   wire                   wr_fire;
   wire                   rd_fire;
   wire [31:0]            wmask;
   wire [31:0]            wmerged;
   reg  [31:0]            rd_mux;
   reg  [`ERB_DW-1:0]     out_a_nxt;
   reg  [`ERB_DW-1:0]     out_b_nxt;

   assign mode     = ctrl_r[`ERB_CTRL_MODE_HI:`ERB_CTRL_MODE_LO];
   assign mp_mode  = ctrl_r[`ERB_CTRL_MP_HI:`ERB_CTRL_MP_LO];
   assign sp_new   = ctrl_r[`ERB_CTRL_SP_NEW];
   assign oreg     = ctrl_r[`ERB_CTRL_OREG];
   assign rden_cfg = ctrl_r[`ERB_CTRL_RDEN];
   assign diffclk  = ctrl_r[`ERB_CTRL_DIFFCLK];
   assign is_shift = (mode == `ERB_MODE_SHIFT);
   assign is_rom   = (mode == `ERB_MODE_ROM);

   // One pending command per cycle, decoded by mode
   assign do_wa = pend_r & pcmd_r[`ERB_CMD_WRA] & ~is_rom;
   assign do_ra = pend_r & (pcmd_r[`ERB_CMD_RDA] | is_shift)
                  & ((mode == `ERB_MODE_SP) | (mode == `ERB_MODE_TDP)
                     | is_rom | is_shift);
   assign do_wb = pend_r & pcmd_r[`ERB_CMD_WRB] & (mode == `ERB_MODE_TDP);
   assign do_rb = pend_r & pcmd_r[`ERB_CMD_RDB]
                  & ((mode == `ERB_MODE_SDP) | (mode == `ERB_MODE_TDP));

   // Shift mode walks a circular pointer; the tap is read before overwrite
   assign ram_addr_a = is_shift ? shift_ptr_r : addr_a_r;
   assign ram_addr_b = addr_b_r;

   erb_ram u_ram
   (
      .aclk    (aclk),
      .we_a    (do_wa),
      .addr_a  (ram_addr_a),
      .wdata_a (wdata_r),
      .rdata_a (ram_q_a),
      .we_b    (do_wb),
      .addr_b  (ram_addr_b),
      .wdata_b (wdata_r),
      .rdata_b (ram_q_b)
   );

   // Output selection one cycle after the access
   always @*
   begin
      out_a_nxt = dout_a_r;
      out_b_nxt = dout_b_r;
      if (rsel_a_r)
      begin
         if (pcmd_r[`ERB_CMD_WRA] & ~is_rom & ~is_shift)
            out_a_nxt = sp_new ? wdata_r : `ERB_DC_WORD;
         else
            out_a_nxt = ram_q_a;
      end
      if (rsel_b_r)
      begin
         if (coll_r & (diffclk | (mp_mode == `ERB_MP_DC)))
            out_b_nxt = `ERB_DC_WORD;
         else if (coll_r & (mp_mode == `ERB_MP_NEW) & oreg)
            out_b_nxt = wdata_r;
         else
            out_b_nxt = ram_q_b;
      end
   end

   // Register-bus write path
   assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_strb
         assign wmask[g*8+7:g*8] = {8{w_strb_r[g]}};
      end
   endgenerate
   assign wmerged = w_data_r & wmask;

   always @*
   begin
      case (s_axi_araddr)
         `ERB_REG_CTRL:   rd_mux = {22'h00_0000, ctrl_r};
         `ERB_REG_STAT:   rd_mux = {16'h0000, opcount_r, 7'h00, pend_r};
         `ERB_REG_ADDR:   rd_mux = {23'h00_0000, addr_a_r};
         `ERB_REG_WDATA:  rd_mux = wdata_r[31:0];
         `ERB_REG_RDATA:  rd_mux = dout_a_r[31:0];
         `ERB_REG_ADDRB:  rd_mux = {23'h00_0000, addr_b_r};
         `ERB_REG_RDATAB: rd_mux = dout_b_r[31:0];
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h0000_0000;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         ctrl_r        <= `ERB_CTRL_RST;
         addr_a_r      <= {`ERB_AW{1'b0}};
         addr_b_r      <= {`ERB_AW{1'b0}};
         wdata_r       <= {`ERB_DW{1'b0}};
         cmd_r         <= 4'h0;
         pend_r        <= 1'b0;
         pcmd_r        <= 4'h0;
         coll_r        <= 1'b0;
         rsel_a_r      <= 1'b0;
         rsel_b_r      <= 1'b0;
         shift_ptr_r   <= {`ERB_AW{1'b0}};
         opcount_r     <= 8'h00;
      end
      else
      begin
         s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         pend_r <= 1'b0;
         if (wr_fire)
         begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            case (aw_addr_r)
               `ERB_REG_CTRL:  ctrl_r   <= wmerged[`ERB_CTRL_W-1:0];
               `ERB_REG_ADDR:  addr_a_r <= wmerged[`ERB_AW-1:0];
               `ERB_REG_ADDRB: addr_b_r <= wmerged[`ERB_AW-1:0];
               `ERB_REG_WDATA: wdata_r  <= {8'h00, wmerged};
               `ERB_REG_CMD:
               begin
                  pend_r <= 1'b1;
                  pcmd_r <= wmerged[3:0];
                  cmd_r  <= wmerged[3:0];
               end
               default:        s_axi_bresp <= 2'b10;
            endcase
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= 2'b00;
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
         rsel_a_r <= do_ra;
         rsel_b_r <= do_rb;
         // Collision of port B read with port A write at one address
         coll_r   <= do_rb & do_wa & (addr_a_r == addr_b_r);
         // A clear written in this very cycle wins over the self-clear
         if (ctrl_r[`ERB_CTRL_CLR] & ~(wr_fire & (aw_addr_r == `ERB_REG_CTRL)))
            ctrl_r[`ERB_CTRL_CLR] <= 1'b0;
         if (is_shift & pend_r)
            shift_ptr_r <= (shift_ptr_r == `ERB_TAP_LEN - 9'h001) ?
                           {`ERB_AW{1'b0}} : shift_ptr_r + 9'h001;
         if (do_wa | do_wb | do_ra | do_rb)
            opcount_r <= opcount_r + 8'h01;
      end
   end

   // No built-in correction; add it outside the block if needed
   // Single clock, all state on its rising edge; rate limit is the user's
   // Output registers: cleared at reset and by the clear bit only
   always @(posedge aclk)
   begin
      if (!aresetn | ctrl_r[`ERB_CTRL_CLR])
      begin
         dout_a_r <= {`ERB_DW{1'b0}};
         dout_b_r <= {`ERB_DW{1'b0}};
      end
      else
      begin
         dout_a_r <= (rden_cfg & ~pcmd_r[`ERB_CMD_RDA] & ~is_shift) ?
                     dout_a_r : out_a_nxt;
         dout_b_r <= out_b_nxt;
      end
   end
endmodule // erb_top
